// ---- rtl/nv_spi_port.sv ----
`timescale 1ns/1ps
module nv_spi_port (
	input  wire logic clk,        // 40 MHz system clock
	input  wire logic reset,      // Synchronous reset, active high
	input  wire logic ce,         // Clock enable, freezes all state when low
	input  wire logic cs_n,       // Select pin
	input  wire logic sck,        // Serial clock pin
	input  wire logic si,         // Serial data in pin
	input  wire logic hold_n,     // Pause pin
	input  wire logic wp_n,       // Write protect pin
	output logic      so_ff,      // Serial data out
	output logic      so_oe_n_ff, // Output enable, low while driving
	output logic      write_enable_latch_flag, // Latch state
	output logic      busy_ff     // High while selected
);

	// ------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ------------------------------------------------------------
	nv_spi_pkg::pins_t meta_ff, pin_ff, last_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_ff <= nv_spi_pkg::PINS_IDLE;
			pin_ff  <= nv_spi_pkg::PINS_IDLE;
			last_ff <= nv_spi_pkg::PINS_IDLE;
		end else if (ce) begin
			meta_ff <= '{cs_n: cs_n, sck: sck, si: si, hold_n: hold_n, wp_n: wp_n};
			pin_ff  <= meta_ff;
			last_ff <= pin_ff;
		end
	end

	// Pause masks every edge; the host only releases it with the clock low
	logic run, sel, rise, fall, cs_fall, cs_rise;
	assign run     = pin_ff.hold_n;
	assign sel     = !pin_ff.cs_n;
	assign rise    = run && sel && pin_ff.sck && !last_ff.sck;
	assign fall    = run && sel && !pin_ff.sck && last_ff.sck;
	assign cs_fall = run && !pin_ff.cs_n && last_ff.cs_n;
	assign cs_rise = run && pin_ff.cs_n && !last_ff.cs_n;

	// ------------------------------------------------------------
	// Byte assembly
	// ------------------------------------------------------------
	nv_spi_pkg::state_t state_ff;
	logic [2:0]  bit_cnt_ff;
	logic [6:0]  in_sh_ff;
	logic [7:0]  in_byte;
	logic        byte_done;
	logic        wr_mode_ff;
	logic [12:0] addr_ff;
	logic        latch_ff;
	logic [1:0]  prot_ff;
	logic        wrote_ff;
	logic [7:0]  mem_rd;
	logic        mem_we;

	assign in_byte   = {in_sh_ff, pin_ff.si};
	assign byte_done = rise && (bit_cnt_ff == nv_spi_pkg::BIT_LAST);
	assign write_enable_latch_flag = latch_ff;

	// Select edges obey the clock enable too, so a frozen edge cannot keep clearing counters
	always_ff @(posedge clk) begin
		if (reset || (ce && (cs_fall || cs_rise))) begin
			bit_cnt_ff <= nv_spi_pkg::BIT_FIRST;
			in_sh_ff   <= 7'h00;
		end else if (ce && rise) begin
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
			in_sh_ff   <= in_byte[6:0];
		end
	end

	// Status byte view; block bits are stored but not enforced here
	function automatic logic [7:0] status_byte(input logic lat, input logic [1:0] prot);
		logic [7:0] s;
		s = 8'h00;
		s[nv_spi_pkg::STAT_LATCH_BIT] = lat;
		s[nv_spi_pkg::STAT_PROT_LSB +: nv_spi_pkg::STAT_PROT_W] = prot;
		return s;
	endfunction : status_byte

	// ------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff   <= nv_spi_pkg::ST_IDLE;
			wr_mode_ff <= 1'b0;
		end else if (ce) begin
			if (cs_rise) begin
				state_ff <= nv_spi_pkg::ST_IDLE;
			end else if (cs_fall) begin
				state_ff <= nv_spi_pkg::ST_CMD;
			end else if (byte_done) begin
				case (state_ff)
				nv_spi_pkg::ST_CMD: begin
					case (in_byte)
					nv_spi_pkg::CMD_STATUS_READ:  state_ff <= nv_spi_pkg::ST_SR_RD;
					nv_spi_pkg::CMD_STATUS_WRITE: state_ff <= nv_spi_pkg::ST_SR_WR;
					nv_spi_pkg::CMD_ARRAY_READ: begin
						state_ff   <= nv_spi_pkg::ST_ADDR_HI;
						wr_mode_ff <= 1'b0;
					end
					nv_spi_pkg::CMD_ARRAY_WRITE: begin
						state_ff   <= nv_spi_pkg::ST_ADDR_HI;
						wr_mode_ff <= 1'b1;
					end
					default: state_ff <= nv_spi_pkg::ST_DONE;
					endcase
				end
				nv_spi_pkg::ST_ADDR_HI: state_ff <= nv_spi_pkg::ST_ADDR_LO;
				nv_spi_pkg::ST_ADDR_LO: begin
					state_ff <= wr_mode_ff ? nv_spi_pkg::ST_WR : nv_spi_pkg::ST_RD;
				end
				nv_spi_pkg::ST_SR_WR: state_ff <= nv_spi_pkg::ST_DONE;
				nv_spi_pkg::ST_IDLE:  state_ff <= nv_spi_pkg::ST_IDLE;
				default:              state_ff <= state_ff;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Address counter, wraps within the array
	// ------------------------------------------------------------
	logic [2:0] out_cnt_ff;
	logic       out_last;
	assign out_last = fall && (out_cnt_ff == nv_spi_pkg::BIT_LAST);

	always_ff @(posedge clk) begin
		if (reset) begin
			addr_ff <= 13'h0000;
		end else if (ce) begin
			if (byte_done && state_ff == nv_spi_pkg::ST_ADDR_HI) begin
				addr_ff[12:8] <= in_byte[nv_spi_pkg::ADDR_HI_BITS-1:0];
			end else if (byte_done && state_ff == nv_spi_pkg::ST_ADDR_LO) begin
				addr_ff[7:0] <= in_byte;
			end else if ((byte_done && state_ff == nv_spi_pkg::ST_WR)
					|| (out_last && state_ff == nv_spi_pkg::ST_RD)) begin
				addr_ff <= addr_ff + 13'h0001;
			end
		end
	end

	// ------------------------------------------------------------
	// Write latch and status bits
	// ------------------------------------------------------------
	assign mem_we = ce && byte_done && state_ff == nv_spi_pkg::ST_WR && latch_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			wrote_ff <= 1'b0;
		end else if (ce) begin
			if (cs_fall || cs_rise) begin
				wrote_ff <= 1'b0;
			end else if (mem_we) begin
				wrote_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			latch_ff <= 1'b0;
			prot_ff  <= nv_spi_pkg::PROT_RESET;
		end else if (ce) begin
			if (cs_rise && wrote_ff) begin
				latch_ff <= 1'b0;
			end else if (byte_done && state_ff == nv_spi_pkg::ST_CMD) begin
				if (in_byte == nv_spi_pkg::CMD_SET_WRITE_LATCH) begin
					latch_ff <= 1'b1;
				end else if (in_byte == nv_spi_pkg::CMD_CLEAR_WRITE_LATCH) begin
					latch_ff <= 1'b0;
				end
			end else if (byte_done && state_ff == nv_spi_pkg::ST_SR_WR
					&& latch_ff && pin_ff.wp_n) begin
				prot_ff  <= in_byte[nv_spi_pkg::STAT_PROT_LSB +: nv_spi_pkg::STAT_PROT_W];
				latch_ff <= 1'b0;
			end
		end
	end

	nv_store nv_store_i (
		.clk      (clk),
		.ce       (ce),
		.we       (mem_we),
		.addr     (addr_ff),
		.wdata    (in_byte),
		.rdata_ff (mem_rd)
	);

	// ------------------------------------------------------------
	// Read data shifter and output driver
	// ------------------------------------------------------------
	// Array data is ready cycles before the first falling edge at 5 MHz
	logic [6:0] out_sh_ff;
	logic       reading;
	logic       drive_ff;
	logic [7:0] src_byte;
	assign reading  = state_ff == nv_spi_pkg::ST_RD || state_ff == nv_spi_pkg::ST_SR_RD;
	assign src_byte = (state_ff == nv_spi_pkg::ST_RD) ? mem_rd : status_byte(latch_ff, prot_ff);

	always_ff @(posedge clk) begin
		if (reset || (ce && (cs_fall || cs_rise))) begin
			out_cnt_ff <= nv_spi_pkg::BIT_FIRST;
			out_sh_ff  <= 7'h00;
			drive_ff   <= 1'b0;
		end else if (ce && fall && reading) begin
			out_cnt_ff <= out_cnt_ff + 3'h1;
			out_sh_ff  <= (out_cnt_ff == nv_spi_pkg::BIT_FIRST) ? src_byte[6:0]
				: {out_sh_ff[5:0], 1'b0};
			drive_ff   <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			so_ff <= 1'b0;
		end else if (ce && fall && reading) begin
			so_ff <= (out_cnt_ff == nv_spi_pkg::BIT_FIRST) ? src_byte[7] : out_sh_ff[6];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			so_oe_n_ff <= 1'b1;
			busy_ff    <= 1'b0;
		end else if (ce) begin
			so_oe_n_ff <= !(drive_ff && reading && sel && run);
			busy_ff    <= sel;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	standby_float_a: assert property (@(posedge clk) disable iff (reset)
		ce && pin_ff.cs_n |=> so_oe_n_ff)
		else $error("output driven while deselected");

	pause_float_a: assert property (@(posedge clk) disable iff (reset)
		ce && !pin_ff.hold_n |=> so_oe_n_ff)
		else $error("output driven while paused");

	drive_only_read_a: assert property (@(posedge clk) disable iff (reset)
		!so_oe_n_ff |-> $past(reading))
		else $error("output driven outside a read");

	out_on_fall_a: assert property (@(posedge clk) disable iff (reset)
		so_ff != $past(so_ff) |-> $past(fall))
		else $error("output changed away from a falling edge");

	in_on_rise_a: assert property (@(posedge clk) disable iff (reset)
		bit_cnt_ff != $past(bit_cnt_ff) |-> $past(rise || cs_fall || cs_rise))
		else $error("input bit counted without a rising edge");

	pause_freeze_a: assert property (@(posedge clk) disable iff (reset)
		ce && !pin_ff.hold_n |=> $stable(state_ff) && $stable(bit_cnt_ff))
		else $error("state moved while paused");

	select_edge_a: assert property (@(posedge clk) disable iff (reset)
		$past(state_ff) == nv_spi_pkg::ST_IDLE && state_ff != nv_spi_pkg::ST_IDLE
			|-> $past(cs_fall))
		else $error("command started without a select edge");

	protect_status_a: assert property (@(posedge clk) disable iff (reset)
		prot_ff != $past(prot_ff) |-> $past(pin_ff.wp_n) && $past(latch_ff))
		else $error("status written while protected");

	latch_cleared_a: assert property (@(posedge clk) disable iff (reset)
		ce && cs_rise && wrote_ff |=> !latch_ff)
		else $error("write latch survived a completed write");

	busy_select_a: assert property (@(posedge clk) disable iff (reset)
		ce |=> busy_ff == $past(sel))
		else $error("busy flag does not follow select");

	latch_set_a: assert property (@(posedge clk) disable iff (reset)
		ce && byte_done && state_ff == nv_spi_pkg::ST_CMD
			&& in_byte == nv_spi_pkg::CMD_SET_WRITE_LATCH |=> latch_ff)
		else $error("set command left the write latch clear");

endmodule : nv_spi_port

// ---- rtl/nv_spi_pkg.sv ----
package nv_spi_pkg;

	// ------------------------------------------------------------
	// Array geometry
	// ------------------------------------------------------------
	localparam int ADDR_W    = 13;
	localparam int DATA_W    = 8;
	localparam int MEM_DEPTH = 8192;

	// ------------------------------------------------------------
	// Command codes, first byte after select
	// ------------------------------------------------------------
	localparam logic [7:0] CMD_SET_WRITE_LATCH   = 8'h06;
	localparam logic [7:0] CMD_CLEAR_WRITE_LATCH = 8'h04;
	localparam logic [7:0] CMD_STATUS_READ       = 8'h05;
	localparam logic [7:0] CMD_STATUS_WRITE      = 8'h01;
	localparam logic [7:0] CMD_ARRAY_READ        = 8'h03;
	localparam logic [7:0] CMD_ARRAY_WRITE       = 8'h02;

	// ------------------------------------------------------------
	// Status byte layout and reset values
	// ------------------------------------------------------------
	localparam int          STAT_LATCH_BIT  = 1;
	localparam int          STAT_PROT_LSB   = 2;
	localparam int          STAT_PROT_W     = 2;
	localparam logic [1:0]  PROT_RESET      = 2'h0;
	localparam logic [2:0]  BIT_LAST        = 3'h7;
	localparam logic [2:0]  BIT_FIRST       = 3'h0;
	localparam int          ADDR_HI_BITS    = 5;

	// ------------------------------------------------------------
	// Carrier for the synchronised pins
	// ------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic sck;
		logic si;
		logic hold_n;
		logic wp_n;
	} pins_t;

	localparam pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, hold_n: 1'b1, wp_n: 1'b1};

	typedef enum logic [3:0] {
		ST_IDLE    = 4'h0,
		ST_CMD     = 4'h1,
		ST_ADDR_HI = 4'h2,
		ST_ADDR_LO = 4'h3,
		ST_RD      = 4'h4,
		ST_WR      = 4'h5,
		ST_SR_RD   = 4'h6,
		ST_SR_WR   = 4'h7,
		ST_DONE    = 4'h8
	} state_t;

endpackage : nv_spi_pkg

// ---- rtl/nv_store.sv ----
`timescale 1ns/1ps
// Byte array with one write port and a registered read port
module nv_store #(
	parameter int DEPTH = nv_spi_pkg::MEM_DEPTH,
	parameter int AW    = nv_spi_pkg::ADDR_W,
	parameter int DW    = nv_spi_pkg::DATA_W
) (
	input  wire logic          clk,     // System clock
	input  wire logic          ce,      // Clock enable
	input  wire logic          we,      // Write strobe
	input  wire logic [AW-1:0] addr,    // Shared address
	input  wire logic [DW-1:0] wdata,   // Write data
	output logic      [DW-1:0] rdata_ff // Read data, one cycle after addr
);

	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (ce) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata_ff <= mem[addr];
		end
	end

	// Checked in the array itself: the port's address has moved on by the next cycle
	write_commit_a: assert property (@(posedge clk)
		ce && we |=> mem[$past(addr)] == $past(wdata))
		else $error("written byte not held by the array");

endmodule : nv_store

// ---- testbench/spi_host_model.sv ----
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clk,        // System clock, paces the pins
	input  wire logic so_ff,      // Device data out
	input  wire logic so_oe_n_ff, // Device output enable, low drives
	output logic      cs_n,       // Select
	output logic      sck,        // Serial clock, 200 ns period
	output logic      si,         // Data to device
	output logic      hold_n      // Pause
);
	logic junk_ff = 1'b0;
	logic so_line;

	// ------------------------------------------------------------
	// Released data line
	// ------------------------------------------------------------
	// No pull on the line, so a floating output reads as a moving pattern
	always_ff @(posedge clk) begin
		junk_ff <= ~junk_ff;
	end
	assign so_line = so_oe_n_ff ? junk_ff : so_ff;

	initial begin
		cs_n   = 1'b1;
		sck    = 1'b0;
		si     = 1'b0;
		hold_n = 1'b1;
	end

	// ------------------------------------------------------------
	// Pin sequences
	// ------------------------------------------------------------
	task automatic half();
		repeat (4) @(posedge clk);
	endtask : half

	// Fresh select edge per command idle level picks the mode
	task automatic sel(input logic idle_hi);
		sck <= idle_hi;
		half();
		cs_n <= 1'b0;
		half();
	endtask : sel

	task automatic desel(input logic idle_hi);
		sck <= idle_hi;
		half();
		cs_n <= 1'b1;
		half();
	endtask : desel

	// MSB first, set while clock low read late in the high phase
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sck <= 1'b0;
			si  <= tx[i];
			half();
			sck <= 1'b1;
			repeat (3) @(posedge clk);
			@(negedge clk);
			rx[i] = so_line;
			@(posedge clk);
		end
	endtask : xfer

	task automatic noise();
		repeat (8) begin
			sck <= ~sck;
			si  <= ~si;
			half();
		end
	endtask : noise

	// Pause changes only with the clock low clock and select wiggle
	task automatic pause(output logic oe_n_seen);
		sck <= 1'b0;
		half();
		hold_n <= 1'b0;
		half();
		sck  <= 1'b1;
		cs_n <= 1'b1;
		half();
		sck  <= 1'b0;
		cs_n <= 1'b0;
		half();
		@(negedge clk);
		oe_n_seen = so_oe_n_ff;
		@(posedge clk);
		hold_n <= 1'b1;
		half();
	endtask : pause
endmodule : spi_host_model

// ---- testbench/nv_spi_port_test.sv ----
`timescale 1ns/1ps
module nv_spi_port_test;
	typedef logic [7:0] bytes_t [$];
	logic   clk;
	logic   reset;
	logic   ce;
	logic   wp_n;
	logic   cs_n;
	logic   sck;
	logic   si;
	logic   hold_n;
	logic   so_ff;
	logic   so_oe_n_ff;
	logic   latch;
	logic   busy_ff;
	int     n_fail = 0;
	int     check_count = 0;
	bytes_t r;

	nv_spi_port nv_spi_port_i (.clk(clk), .reset(reset), .ce(ce), .cs_n(cs_n), .sck(sck),
		.si(si), .hold_n(hold_n), .wp_n(wp_n), .so_ff(so_ff), .so_oe_n_ff(so_oe_n_ff),
		.write_enable_latch_flag(latch), .busy_ff(busy_ff));
	spi_host_model spi_host_model_i (.clk(clk), .so_ff(so_ff), .so_oe_n_ff(so_oe_n_ff),
		.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize

	task automatic frame(input logic m, input bytes_t tx, output bytes_t rx);
		logic [7:0] b;
		rx = {};
		spi_host_model_i.sel(m);
		foreach (tx[i]) begin
			spi_host_model_i.xfer(tx[i], b);
			rx.push_back(b);
		end
		spi_host_model_i.desel(m);
	endtask : frame

	task automatic op(input logic [7:0] code);
		frame(1'b0, {code}, r);
	endtask : op

	task automatic status_is(input logic [7:0] exp);
		frame(1'b0, {nv_spi_pkg::CMD_STATUS_READ, 8'h00}, r);
		check(r[1], exp);
	endtask : status_is

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_idle();
		check({7'h00, latch}, 8'h00);
		spi_host_model_i.noise();
		check({6'h00, busy_ff, so_oe_n_ff}, 8'h01);
		check({7'h00, latch}, 8'h00);
		$display("test idle done");
	endtask : t_idle

	task automatic t_array();
		op(nv_spi_pkg::CMD_SET_WRITE_LATCH);
		check({7'h00, latch}, 8'h01);
		frame(1'b0, {nv_spi_pkg::CMD_ARRAY_WRITE, 8'hff, 8'hff, 8'h5a, 8'hc3}, r);
		check({7'h00, latch}, 8'h00);
		frame(1'b1, {nv_spi_pkg::CMD_ARRAY_READ, 8'he0, 8'h00, 8'h00}, r);
		check(r[3], 8'hc3);
		frame(1'b0, {nv_spi_pkg::CMD_ARRAY_READ, 8'h1f, 8'hff, 8'h00, 8'h00}, r);
		check(r[3], 8'h5a);
		check(r[4], 8'hc3);
		frame(1'b0, {nv_spi_pkg::CMD_ARRAY_WRITE, 8'h00, 8'h00, 8'h11}, r);
		op(nv_spi_pkg::CMD_SET_WRITE_LATCH);
		frame(1'b0, {8'hff, nv_spi_pkg::CMD_ARRAY_WRITE, 8'h00, 8'h00, 8'h22}, r);
		check({7'h00, latch}, 8'h01);
		frame(1'b1, {nv_spi_pkg::CMD_ARRAY_READ, 8'h00, 8'h00, 8'h00}, r);
		check(r[3], 8'hc3);
		$display("test array done");
	endtask : t_array

	task automatic t_status();
		op(nv_spi_pkg::CMD_SET_WRITE_LATCH);
		@(posedge clk);
		wp_n <= 1'b0;
		frame(1'b0, {nv_spi_pkg::CMD_STATUS_WRITE, 8'h0c}, r);
		status_is(8'h02);
		frame(1'b0, {nv_spi_pkg::CMD_ARRAY_WRITE, 8'h00, 8'h05, 8'h77}, r);
		frame(1'b0, {nv_spi_pkg::CMD_ARRAY_READ, 8'h00, 8'h05, 8'h00}, r);
		check(r[3], 8'h77);
		@(posedge clk);
		wp_n <= 1'b1;
		op(nv_spi_pkg::CMD_SET_WRITE_LATCH);
		frame(1'b0, {nv_spi_pkg::CMD_STATUS_WRITE, 8'h0c}, r);
		status_is(8'h0c);
		op(nv_spi_pkg::CMD_SET_WRITE_LATCH);
		op(nv_spi_pkg::CMD_CLEAR_WRITE_LATCH);
		status_is(8'h0c);
		$display("test status done");
	endtask : t_status

	task automatic t_hold();
		logic [7:0] b;
		logic       oe_n;
		spi_host_model_i.sel(1'b0);
		spi_host_model_i.xfer(nv_spi_pkg::CMD_ARRAY_READ, b);
		check({7'h00, busy_ff}, 8'h01);
		spi_host_model_i.xfer(8'h1f, b);
		spi_host_model_i.xfer(8'hff, b);
		spi_host_model_i.pause(oe_n);
		check({7'h00, oe_n}, 8'h01);
		ce <= 1'b0;
		repeat (40) @(posedge clk);
		ce <= 1'b1;
		spi_host_model_i.xfer(8'h00, b);
		check(b, 8'h5a);
		spi_host_model_i.desel(1'b0);
		$display("test hold done");
	endtask : t_hold

	initial begin
		reset = 1'b1;
		ce    = 1'b1;
		wp_n  = 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		repeat (8) @(posedge clk);
		t_idle();
		t_array();
		t_status();
		t_hold();
		summarize();
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		summarize();
	end
endmodule : nv_spi_port_test
